// file: hw/wakeup_meas_pkg.sv
`default_nettype none
package wakeup_meas_pkg;

	// Register offsets on the 6-bit register address.
	localparam logic [5:0] AMP_CFG_OFFSET = 6'h32;
	localparam logic [5:0] AMP_REF_OFFSET = 6'h33;
	localparam logic [5:0] AMP_AVG_OFFSET = 6'h34;
	localparam logic [5:0] AMP_RESULT_OFFSET = 6'h35;
	localparam logic [5:0] PHASE_CFG_OFFSET = 6'h36;

	localparam int ADDR_WIDTH = 6;
	localparam int DATA_WIDTH = 8;

	// Configuration field positions, shared by amplitude and phase.
	localparam int THRESHOLD_MSB = 7;
	localparam int THRESHOLD_LSB = 4;
	localparam int INCLUDE_IRQ_BIT = 3;
	localparam int WEIGHT_MSB = 2;
	localparam int WEIGHT_LSB = 1;
	localparam int USE_AVERAGE_BIT = 0;

	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] REF_RESET = 8'h00;
	localparam logic [7:0] RESULT_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// Weight 4 is a shift by two; each code step doubles the weight.
	localparam logic [2:0] WEIGHT_BASE_SHIFT = 3'h2;

	function automatic logic [7:0] absDiff(input logic [7:0] a, input logic [7:0] b);
		absDiff = (a > b) ? (a - b) : (b - a);
	endfunction

	// Moves the average toward the sample by one weighted step.
	function automatic logic [7:0] avgStep(input logic [7:0] avg, input logic [7:0] sample,
			input logic [1:0] weight);
		logic signed [9:0] delta;
		logic [2:0] shift;
		logic [9:0] sum;
		delta = signed'({2'b00, sample}) - signed'({2'b00, avg});
		shift = {1'b0, weight} + WEIGHT_BASE_SHIFT;
		delta = delta >>> shift;
		sum = {2'b00, avg} + unsigned'(delta);
		avgStep = sum[7:0];
	endfunction

endpackage
`default_nettype wire

// file: hw/meas_chan_if.sv
`default_nettype none
interface meas_chan_if;
	logic clearAll;
	logic [7:0] cfg;
	logic [7:0] refValue;
	logic sampleValid;
	logic [7:0] sample;
	logic [7:0] average;
	logic [7:0] lastResult;
	logic irq;

	modport owner (output clearAll, output cfg, output refValue, output sampleValid,
		output sample, input average, input lastResult, input irq);
	modport channel (input clearAll, input cfg, input refValue, input sampleValid,
		input sample, output average, output lastResult, output irq);
endinterface
`default_nettype wire

// file: hw/meas_channel.sv
`default_nettype none
module meas_channel (
	input wire logic clk,
	input wire logic rst_b,
	meas_chan_if.channel ch
);
	import wakeup_meas_pkg::*;

	logic [7:0] avg_r;
	logic [7:0] result_r;
	logic irq_r;
	logic [7:0] compareBase;
	logic overThreshold;
	logic [3:0] threshold;

	assign threshold = ch.cfg[THRESHOLD_MSB:THRESHOLD_LSB];

	assign compareBase = ch.cfg[USE_AVERAGE_BIT] ? avg_r : ch.refValue;

	assign overThreshold = absDiff(ch.sample, compareBase) > {4'h0, threshold};

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			avg_r <= RESULT_RESET;
		end else if (ch.clearAll) begin
			avg_r <= RESULT_RESET;
		end else if (ch.sampleValid && (!overThreshold || ch.cfg[INCLUDE_IRQ_BIT])) begin
			avg_r <= avgStep(avg_r, ch.sample, ch.cfg[WEIGHT_MSB:WEIGHT_LSB]);
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			result_r <= RESULT_RESET;
		end else if (ch.clearAll) begin
			result_r <= RESULT_RESET;
		end else if (ch.sampleValid) begin
			result_r <= ch.sample;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= ch.sampleValid && overThreshold && !ch.clearAll;
		end
	end

	assign ch.average = avg_r;
	assign ch.lastResult = result_r;
	assign ch.irq = irq_r;

	property p_irq_on_exceed;
		@(posedge clk) disable iff (!rst_b)
		(ch.sampleValid && !ch.clearAll && absDiff(ch.sample, compareBase) > {4'h0, threshold})
			|=> ch.irq;
	endproperty
	a_irq_on_exceed: assert property (p_irq_on_exceed) else $error("missed wake-up event");

	property p_no_irq_at_equal;
		@(posedge clk) disable iff (!rst_b)
		(ch.sampleValid && absDiff(ch.sample, compareBase) <= {4'h0, threshold}) |=> !ch.irq;
	endproperty
	a_no_irq_at_equal: assert property (p_no_irq_at_equal) else $error("event on equal");

	property p_excluded_sample;
		@(posedge clk) disable iff (!rst_b)
		(ch.sampleValid && !ch.clearAll && overThreshold && !ch.cfg[INCLUDE_IRQ_BIT])
			|=> $stable(ch.average);
	endproperty
	a_excluded_sample: assert property (p_excluded_sample) else $error("average moved");

	property p_average_step;
		@(posedge clk) disable iff (!rst_b)
		(ch.sampleValid && !ch.clearAll && !overThreshold && ch.cfg[WEIGHT_MSB:WEIGHT_LSB] == 2'b00)
			|=> ch.average == avgStep($past(ch.average), $past(ch.sample), 2'b00);
	endproperty
	a_average_step: assert property (p_average_step) else $error("wrong average update");

	property p_result_capture;
		@(posedge clk) disable iff (!rst_b)
		(ch.sampleValid && !ch.clearAll) |=> ch.lastResult == $past(ch.sample);
	endproperty
	a_result_capture: assert property (p_result_capture) else $error("result not captured");

	property p_clear_results;
		@(posedge clk) disable iff (!rst_b)
		ch.clearAll |=> (ch.average == RESULT_RESET && ch.lastResult == RESULT_RESET && !ch.irq);
	endproperty
	a_clear_results: assert property (p_clear_results) else $error("results not cleared");

endmodule // meas_channel
`default_nettype wire

// file: hw/wakeup_amp_phase_measure_regs.sv
`default_nettype none
module wakeup_amp_phase_measure_regs (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [wakeup_meas_pkg::ADDR_WIDTH-1:0] regAddr,
	input wire logic regWrEn,
	input wire logic [wakeup_meas_pkg::DATA_WIDTH-1:0] regWrData,
	input wire logic regRdEn,
	output logic [wakeup_meas_pkg::DATA_WIDTH-1:0] regRdData,
	input wire logic setDefault,
	input wire logic timerExpiry,
	input wire logic ampCheckEnable,
	input wire logic phaseCheckEnable,
	input wire logic [wakeup_meas_pkg::DATA_WIDTH-1:0] phaseReferenceValue,
	output logic ampMeasureStart,
	output logic phaseMeasureStart,
	input wire logic ampResultValid,
	input wire logic [wakeup_meas_pkg::DATA_WIDTH-1:0] ampResult,
	input wire logic phaseResultValid,
	input wire logic [wakeup_meas_pkg::DATA_WIDTH-1:0] phaseResult,
	output logic ampWakeEvent,
	output logic phaseWakeEvent,
	output logic [wakeup_meas_pkg::DATA_WIDTH-1:0] phaseAverage,
	output logic [wakeup_meas_pkg::DATA_WIDTH-1:0] phaseLastResult
);
	import wakeup_meas_pkg::*;

	logic [7:0] ampCfg_r;
	logic [7:0] ampRef_r;
	logic [7:0] phaseCfg_r;
	logic [7:0] rdData_r;
	logic [7:0] rdData_nxt;
	logic ampStart_r;
	logic phaseStart_r;
	logic ampOver;

	meas_chan_if ampChan ();
	meas_chan_if phaseChan ();

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ampCfg_r <= CFG_RESET;
			ampRef_r <= REF_RESET;
			phaseCfg_r <= CFG_RESET;
		end else if (setDefault) begin
			ampCfg_r <= CFG_RESET;
			ampRef_r <= REF_RESET;
			phaseCfg_r <= CFG_RESET;
		end else if (regWrEn) begin
			// Writes to read-only or unmapped offsets are dropped silently.
			case (regAddr)
				AMP_CFG_OFFSET: begin
					ampCfg_r <= regWrData;
				end
				AMP_REF_OFFSET: begin
					ampRef_r <= regWrData;
				end
				PHASE_CFG_OFFSET: begin
					phaseCfg_r <= regWrData;
				end
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		rdData_nxt = UNMAPPED_READ;
		case (regAddr)
			AMP_CFG_OFFSET: begin
				rdData_nxt = ampCfg_r;
			end
			AMP_REF_OFFSET: begin
				rdData_nxt = ampRef_r;
			end
			AMP_AVG_OFFSET: begin
				rdData_nxt = ampChan.average;
			end
			AMP_RESULT_OFFSET: begin
				rdData_nxt = ampChan.lastResult;
			end
			PHASE_CFG_OFFSET: begin
				rdData_nxt = phaseCfg_r;
			end
			default: begin
				rdData_nxt = UNMAPPED_READ;
			end
		endcase
	end

	// Read data is held until the next read so the host may sample it late.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdData_r <= UNMAPPED_READ;
		end else if (regRdEn) begin
			rdData_r <= rdData_nxt;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ampStart_r <= 1'b0;
			phaseStart_r <= 1'b0;
		end else begin
			ampStart_r <= timerExpiry && ampCheckEnable && !setDefault;
			phaseStart_r <= timerExpiry && phaseCheckEnable && !setDefault;
		end
	end

	assign ampChan.clearAll = setDefault;
	assign ampChan.cfg = ampCfg_r;
	assign ampChan.refValue = ampRef_r;
	assign ampChan.sampleValid = ampResultValid;
	assign ampChan.sample = ampResult;

	assign phaseChan.clearAll = setDefault;
	assign phaseChan.cfg = phaseCfg_r;
	assign phaseChan.refValue = phaseReferenceValue;
	assign phaseChan.sampleValid = phaseResultValid;
	assign phaseChan.sample = phaseResult;

	meas_channel ampUnit (
		.clk(clk),
		.rst_b(rst_b),
		.ch(ampChan)
	);

	meas_channel phaseUnit (
		.clk(clk),
		.rst_b(rst_b),
		.ch(phaseChan)
	);

	assign regRdData = rdData_r;
	assign ampMeasureStart = ampStart_r;
	assign phaseMeasureStart = phaseStart_r;
	assign ampWakeEvent = ampChan.irq;
	assign phaseWakeEvent = phaseChan.irq;
	assign phaseAverage = phaseChan.average;
	assign phaseLastResult = phaseChan.lastResult;

	// Mirrors the amplitude unit's compare so the averaging checks can tell included samples.
	assign ampOver = absDiff(ampResult, ampCfg_r[USE_AVERAGE_BIT] ? ampChan.average : ampRef_r)
		> {4'h0, ampCfg_r[THRESHOLD_MSB:THRESHOLD_LSB]};

	property p_amp_start;
		@(posedge clk) disable iff (!rst_b)
		(timerExpiry && ampCheckEnable && !setDefault) |=> ampMeasureStart;
	endproperty
	a_amp_start: assert property (p_amp_start) else $error("amp start missing");

	property p_amp_no_start;
		@(posedge clk) disable iff (!rst_b)
		!(timerExpiry && ampCheckEnable) |=> !ampMeasureStart;
	endproperty
	a_amp_no_start: assert property (p_amp_no_start) else $error("spurious amplitude start");

	property p_phase_start;
		@(posedge clk) disable iff (!rst_b)
		(timerExpiry && phaseCheckEnable && !setDefault) |=> phaseMeasureStart;
	endproperty
	a_phase_start: assert property (p_phase_start) else $error("phase start missing");

	property p_default_clears;
		@(posedge clk) disable iff (!rst_b)
		setDefault |=> (ampCfg_r == CFG_RESET && ampRef_r == REF_RESET
			&& phaseCfg_r == CFG_RESET);
	endproperty
	a_default_clears: assert property (p_default_clears) else $error("config not cleared");

	property p_ref_write;
		@(posedge clk) disable iff (!rst_b)
		(regWrEn && !setDefault && regAddr == AMP_REF_OFFSET) ##1 (regRdEn
			&& !regWrEn && regAddr == AMP_REF_OFFSET) |=> regRdData == $past(regWrData, 2);
	endproperty
	a_ref_write: assert property (p_ref_write) else $error("reference readback mismatch");

	property p_avg_read;
		@(posedge clk) disable iff (!rst_b)
		(regRdEn && regAddr == AMP_AVG_OFFSET) |=> regRdData == $past(ampChan.average);
	endproperty
	a_avg_read: assert property (p_avg_read) else $error("average readback mismatch");

	property p_result_read;
		@(posedge clk) disable iff (!rst_b)
		(regRdEn && regAddr == AMP_RESULT_OFFSET) |=> regRdData == $past(ampChan.lastResult);
	endproperty
	a_result_read: assert property (p_result_read) else $error("result readback mismatch");

	property p_amp_base_select;
		@(posedge clk) disable iff (!rst_b)
		(ampResultValid && !setDefault && ampCfg_r[USE_AVERAGE_BIT] == 1'b0
			&& absDiff(ampResult, ampRef_r) > {4'h0, ampCfg_r[THRESHOLD_MSB:THRESHOLD_LSB]})
			|=> ampWakeEvent;
	endproperty
	a_amp_base_select: assert property (p_amp_base_select) else $error("ref base ignored");

	property p_phase_base_select;
		@(posedge clk) disable iff (!rst_b)
		(phaseResultValid && phaseCfg_r[USE_AVERAGE_BIT]
			&& absDiff(phaseResult, phaseChan.average)
			<= {4'h0, phaseCfg_r[THRESHOLD_MSB:THRESHOLD_LSB]}) |=> !phaseWakeEvent;
	endproperty
	a_phase_base_select: assert property (p_phase_base_select) else $error("base ignored");

	property p_weight_32;
		@(posedge clk) disable iff (!rst_b)
		(ampResultValid && !setDefault && !ampOver && ampCfg_r[WEIGHT_MSB:WEIGHT_LSB] == 2'b11)
			|=> ampChan.average == avgStep($past(ampChan.average), $past(ampResult), 2'b11);
	endproperty
	a_weight_32: assert property (p_weight_32) else $error("weight 32 step wrong");

	property p_weight_4;
		@(posedge clk) disable iff (!rst_b)
		(ampResultValid && !setDefault && !ampOver && ampCfg_r[WEIGHT_MSB:WEIGHT_LSB] == 2'b00)
			|=> ampChan.average == avgStep($past(ampChan.average), $past(ampResult), 2'b00);
	endproperty
	a_weight_4: assert property (p_weight_4) else $error("weight 4 step wrong");

	property p_weight_8;
		@(posedge clk) disable iff (!rst_b)
		(ampResultValid && !setDefault && !ampOver && ampCfg_r[WEIGHT_MSB:WEIGHT_LSB] == 2'b01)
			|=> ampChan.average == avgStep($past(ampChan.average), $past(ampResult), 2'b01);
	endproperty
	a_weight_8: assert property (p_weight_8) else $error("weight 8 step wrong");

	property p_weight_16;
		@(posedge clk) disable iff (!rst_b)
		(ampResultValid && !setDefault && !ampOver && ampCfg_r[WEIGHT_MSB:WEIGHT_LSB] == 2'b10)
			|=> ampChan.average == avgStep($past(ampChan.average), $past(ampResult), 2'b10);
	endproperty
	a_weight_16: assert property (p_weight_16) else $error("weight 16 step wrong");

	property p_amp_include;
		@(posedge clk) disable iff (!rst_b)
		(ampResultValid && !setDefault && ampOver && ampCfg_r[INCLUDE_IRQ_BIT]
			&& ampCfg_r[WEIGHT_MSB:WEIGHT_LSB] == 2'b00)
			|=> ampChan.average == avgStep($past(ampChan.average), $past(ampResult), 2'b00);
	endproperty
	a_amp_include: assert property (p_amp_include) else $error("included sample skipped");

	property p_amp_avg_base;
		@(posedge clk) disable iff (!rst_b)
		(ampResultValid && !setDefault && ampCfg_r[USE_AVERAGE_BIT]
			&& absDiff(ampResult, ampChan.average) > {4'h0, ampCfg_r[THRESHOLD_MSB:THRESHOLD_LSB]})
			|=> ampWakeEvent;
	endproperty
	a_amp_avg_base: assert property (p_amp_avg_base) else $error("average base ignored");

	property p_phase_ref_base;
		@(posedge clk) disable iff (!rst_b)
		(phaseResultValid && !setDefault && !phaseCfg_r[USE_AVERAGE_BIT]
			&& absDiff(phaseResult, phaseReferenceValue)
			> {4'h0, phaseCfg_r[THRESHOLD_MSB:THRESHOLD_LSB]}) |=> phaseWakeEvent;
	endproperty
	a_phase_ref_base: assert property (p_phase_ref_base) else $error("ref base missed");

	property p_amp_ref_quiet;
		@(posedge clk) disable iff (!rst_b)
		(ampResultValid && !ampCfg_r[USE_AVERAGE_BIT]
			&& absDiff(ampResult, ampRef_r) <= {4'h0, ampCfg_r[THRESHOLD_MSB:THRESHOLD_LSB]})
			|=> !ampWakeEvent;
	endproperty
	a_amp_ref_quiet: assert property (p_amp_ref_quiet) else $error("quiet event");

	property p_phase_no_start;
		@(posedge clk) disable iff (!rst_b)
		!(timerExpiry && phaseCheckEnable) |=> !phaseMeasureStart;
	endproperty
	a_phase_no_start: assert property (p_phase_no_start) else $error("stray phase start");

	property p_cfg_write;
		@(posedge clk) disable iff (!rst_b)
		(regWrEn && !setDefault && regAddr == AMP_CFG_OFFSET) |=> ampCfg_r == $past(regWrData);
	endproperty
	a_cfg_write: assert property (p_cfg_write) else $error("amp config write lost");

	property p_phase_cfg_write;
		@(posedge clk) disable iff (!rst_b)
		(regWrEn && !setDefault && regAddr == PHASE_CFG_OFFSET)
			|=> phaseCfg_r == $past(regWrData);
	endproperty
	a_phase_cfg_write: assert property (p_phase_cfg_write) else $error("phase cfg lost");

	property p_ro_write_ignored;
		@(posedge clk) disable iff (!rst_b)
		(regWrEn && !setDefault && (regAddr == AMP_AVG_OFFSET || regAddr == AMP_RESULT_OFFSET))
			|=> ($stable(ampCfg_r) && $stable(ampRef_r) && $stable(phaseCfg_r));
	endproperty
	a_ro_write_ignored: assert property (p_ro_write_ignored) else $error("write landed");

	property p_rd_hold;
		@(posedge clk) disable iff (!rst_b)
		!regRdEn |=> $stable(regRdData);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data changed");

endmodule // wakeup_amp_phase_measure_regs
`default_nettype wire

// file: bench/wakeup_amp_phase_measure_regs_tb_top.sv
`default_nettype none
module wakeup_amp_phase_measure_regs_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import wakeup_meas_pkg::*;

	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [5:0] regAddr = 6'h00;
	logic regWrEn = 1'b0;
	logic [7:0] regWrData = 8'h00;
	logic regRdEn = 1'b0;
	logic setDefault = 1'b0;
	logic timerExpiry = 1'b0;
	logic ampCheckEnable = 1'b0;
	logic phaseCheckEnable = 1'b0;
	logic [7:0] phaseReferenceValue = 8'h00;
	logic ampResultValid = 1'b0;
	logic [7:0] ampResult = 8'h00;
	logic phaseResultValid = 1'b0;
	logic [7:0] phaseResult = 8'h00;
	logic [7:0] regRdData;
	logic [7:0] phaseAverage;
	logic [7:0] phaseLastResult;
	logic ampMeasureStart;
	logic phaseMeasureStart;
	logic ampWakeEvent;
	logic phaseWakeEvent;
	int n_errors = 0;
	int total_checks = 0;
	int seed = 32'h2ed70d8d;
	// Expected state, index 0 for amplitude and 1 for phase.
	logic [7:0] cfgM [2];
	logic [7:0] avgM [2];
	logic [7:0] lastM [2];
	logic [7:0] refM [2];

	wakeup_amp_phase_measure_regs dut_u (.clk(clk), .rst_b(rst_b), .regAddr(regAddr),
		.regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
		.setDefault(setDefault), .timerExpiry(timerExpiry), .ampCheckEnable(ampCheckEnable),
		.phaseCheckEnable(phaseCheckEnable), .phaseReferenceValue(phaseReferenceValue),
		.ampMeasureStart(ampMeasureStart), .phaseMeasureStart(phaseMeasureStart),
		.ampResultValid(ampResultValid), .ampResult(ampResult),
		.phaseResultValid(phaseResultValid), .phaseResult(phaseResult),
		.ampWakeEvent(ampWakeEvent), .phaseWakeEvent(phaseWakeEvent),
		.phaseAverage(phaseAverage), .phaseLastResult(phaseLastResult));

	initial begin
		forever #5 clk = ~clk;
	end

	// Integer shift floors toward minus infinity, as the averaging step must.
	function automatic logic [7:0] nextAvg(logic [7:0] avg, logic [7:0] s, logic [1:0] w);
		int d;
		d = int'(s) - int'(avg);
		return 8'(int'(avg) + (d >>> (2 + int'(w))));
	endfunction

	function automatic logic eventExp(logic [7:0] s, logic [7:0] base, logic [7:0] c);
		int d;
		d = int'(s) - int'(base);
		if (d < 0) d = -d;
		return d > int'(c[7:4]);
	endfunction

	function automatic logic [7:0] baseOf(int ch);
		return cfgM[ch][0] ? avgM[ch] : refM[ch];
	endfunction

	task automatic chkByte(input logic [7:0] got, input logic [7:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic chkBit(input logic got, input logic exp, input string what);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t %s got %b expected %b", $time, what, got, exp);
		end
	endtask

	task automatic clearModel();
		for (int k = 0; k < 2; k++) begin
			cfgM[k] = 8'h00;
			avgM[k] = 8'h00;
			lastM[k] = 8'h00;
			refM[k] = 8'h00;
		end
	endtask

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1'b1;
		@(posedge clk);
		regWrEn <= 1'b0;
	endtask

	// Write followed at once by a read of the same place, the tightest legal spacing.
	task automatic wrRd(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1'b1;
		@(posedge clk);
		regWrEn <= 1'b0;
		regRdEn <= 1'b1;
		@(posedge clk);
		regRdEn <= 1'b0;
		#1;
		chkByte(regRdData, d, "write then read");
	endtask

	task automatic rd(input logic [5:0] a, input logic [7:0] exp);
		@(posedge clk);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge clk);
		regRdEn <= 1'b0;
		#1;
		chkByte(regRdData, exp, "read data");
	endtask

	task automatic readAllZero();
		for (int a = 'h32; a <= 'h36; a++) begin
			rd(6'(a), 8'h00);
		end
		chkByte(phaseAverage, 8'h00, "phase average");
		chkByte(phaseLastResult, 8'h00, "phase result");
	endtask

	task automatic samp(input int ch, input logic [7:0] s);
		logic evt;
		evt = eventExp(s, baseOf(ch), cfgM[ch]);
		@(posedge clk);
		if (ch == 0) begin
			ampResultValid <= 1'b1;
			ampResult <= s;
		end else begin
			phaseResultValid <= 1'b1;
			phaseResult <= s;
		end
		@(posedge clk);
		ampResultValid <= 1'b0;
		phaseResultValid <= 1'b0;
		#1;
		lastM[ch] = s;
		if (!evt || cfgM[ch][3]) avgM[ch] = nextAvg(avgM[ch], s, cfgM[ch][2:1]);
		chkBit(ch == 0 ? ampWakeEvent : phaseWakeEvent, evt, "wake event");
		if (ch == 0) begin
			rd(AMP_RESULT_OFFSET, lastM[0]);
			rd(AMP_AVG_OFFSET, avgM[0]);
		end else begin
			chkByte(phaseLastResult, lastM[1], "phase result");
			chkByte(phaseAverage, avgM[1], "phase average");
		end
	endtask

	task automatic launch(input logic a, input logic p, input logic sd);
		@(posedge clk);
		ampCheckEnable <= a;
		phaseCheckEnable <= p;
		timerExpiry <= 1'b1;
		setDefault <= sd;
		@(posedge clk);
		timerExpiry <= 1'b0;
		setDefault <= 1'b0;
		#1;
		chkBit(ampMeasureStart, a & ~sd, "amp start");
		chkBit(phaseMeasureStart, p & ~sd, "phase start");
		@(posedge clk);
		#1;
		chkBit(ampMeasureStart | phaseMeasureStart, 1'b0, "start length");
	endtask

	task automatic conclude();
		$display("Checks: %0d, errors: %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		int ch;
		int off;
		int v;
		logic [7:0] c;
		clearModel();
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		readAllZero();
		rd(6'h3f, UNMAPPED_READ);
		wrRd(AMP_REF_OFFSET, 8'h5a);
		// Read-only places must ignore writes.
		wr(AMP_AVG_OFFSET, 8'hff);
		wr(AMP_RESULT_OFFSET, 8'hff);
		rd(AMP_AVG_OFFSET, 8'h00);
		rd(AMP_RESULT_OFFSET, 8'h00);
		for (int i = 0; i < 48; i++) begin
			ch = i % 2;
			c = 8'($random(seed));
			c[2:1] = 2'(i / 2);
			cfgM[ch] = c;
			refM[ch] = 8'($random(seed));
			wr(ch == 0 ? AMP_CFG_OFFSET : PHASE_CFG_OFFSET, c);
			if (ch == 0) begin
				wr(AMP_REF_OFFSET, refM[0]);
			end else begin
				@(posedge clk);
				phaseReferenceValue <= refM[1];
			end
			// Every third sample sits exactly on the threshold edge, on both channels.
			off = (i % 3 == 2) ? int'(c[7:4]) : $random(seed) % 20;
			v = int'(baseOf(ch)) + off;
			if (v < 0) v = 0;
			if (v > 255) v = 255;
			samp(ch, 8'(v));
		end
		rd(AMP_CFG_OFFSET, cfgM[0]);
		rd(PHASE_CFG_OFFSET, cfgM[1]);
		// Set Default beats a write and samples landing in the same cycle.
		@(posedge clk);
		setDefault <= 1'b1;
		regAddr <= AMP_REF_OFFSET;
		regWrData <= 8'hff;
		regWrEn <= 1'b1;
		ampResultValid <= 1'b1;
		ampResult <= 8'hc3;
		phaseResultValid <= 1'b1;
		phaseResult <= 8'h3c;
		@(posedge clk);
		setDefault <= 1'b0;
		regWrEn <= 1'b0;
		ampResultValid <= 1'b0;
		phaseResultValid <= 1'b0;
		#1;
		chkBit(ampWakeEvent | phaseWakeEvent, 1'b0, "event under default");
		clearModel();
		readAllZero();
		for (int k = 0; k < 4; k++) begin
			launch(k[0], k[1], 1'b0);
		end
		launch(1'b1, 1'b1, 1'b1);
		readAllZero();
		conclude();
	end

	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		conclude();
	end
endmodule // wakeup_amp_phase_measure_regs_tb_top
`default_nettype wire
